// File: afr_pkg.sv
// Shared constants for the front-end register map and continuous readout
package afr_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [3:0] IDX_CH0    = 4'h0;
  localparam logic [3:0] IDX_CH1    = 4'h3;
  localparam logic [3:0] IDX_RSVD   = 4'h6;
  localparam logic [3:0] IDX_PHASE  = 4'h7;
  localparam logic [3:0] IDX_GAIN   = 4'h8;
  localparam logic [3:0] IDX_STAT   = 4'h9;
  localparam logic [3:0] IDX_CFGA   = 4'hA;
  localparam logic [3:0] IDX_CFGB   = 4'hB;
  localparam logic [3:0] IDX_LOOP   = 4'hC;
  localparam logic [3:0] IDX_STREAM = 4'hD;
  localparam logic [3:0] IDX_GRP1   = 4'h2;
  localparam logic [3:0] IDX_GRP2   = 4'h5;
  localparam int         ADDR_W     = 6;
  // Readout-loop control fields
  localparam int LOOP_SEL_LSB   = 0;
  localparam int LOOP_RUN_BIT   = 2;
  localparam int LOOP_START_LSB = 4;
  localparam logic [1:0] LOOP_NONE  = 2'h0;
  localparam logic [1:0] LOOP_GROUP = 2'h1;
  localparam logic [1:0] LOOP_TYPE  = 2'h2;
  localparam logic [1:0] LOOP_ALL   = 2'h3;
  // Reset values and bus answers
  localparam logic [7:0]  RST_CFG    = 8'h00;
  localparam logic [23:0] RST_SAMPLE = 24'h00_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int SAMPLE_W   = 24;
  localparam int FIFO_DEPTH = 16;
endpackage : afr_pkg

// File: afr_top.sv
// Front-end register bank with sample FIFO and continuous-read sequencing
// What this block does
// - Every register is an individually addressed byte.
// - Channel 0 result at 0x00, MSB first, read-only.
// - Channel 1 result at 0x03, MSB first, read-only.
// - Registers 0x07 to 0x0B readable and writable.
// - Loop selector picks the address set looped.
// - 11 whole map, 10 type, 01 group.
// - Results held while a looped read is running (loop run bit set).
// - Both channels' three bytes refresh together.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module afr_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,     // Clock
  input  wire logic             rst_n_i,   // Async reset, active low
  input  wire logic             in_valid_i, // Write side valid
  output logic                  in_ready_o, // Write side ready
  input  wire logic [WIDTH-1:0] in_data_i, // Write data
  output logic                  out_valid_o, // Read side valid
  input  wire logic             out_ready_i, // Read side ready
  output logic      [WIDTH-1:0] out_data_o // Head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[PW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; only the pointers define content
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end
endmodule : afr_fifo

module afr_top #(
  parameter int FIFO_DEPTH = afr_pkg::FIFO_DEPTH
) (
  input  wire logic                       REF_CLK_I,       // 250 MHz clock
  input  wire logic                       RSTN_I,          // Async reset, active low
  input  wire logic [afr_pkg::SAMPLE_W-1:0] CH0_SAMPLE_I,  // Channel 0 conversion
  input  wire logic [afr_pkg::SAMPLE_W-1:0] CH1_SAMPLE_I,  // Channel 1 conversion
  input  wire logic                       SAMPLE_VALID_I,  // Sample pair offered
  output logic                            SAMPLE_READY_O,  // FIFO can take a pair
  input  wire logic [afr_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,  // Write address
  input  wire logic                       S_AXI_AWVALID_I, // Write address valid
  output logic                            S_AXI_AWREADY_O, // Write address ready
  input  wire logic [31:0]                S_AXI_WDATA_I,   // Write data
  input  wire logic [3:0]                 S_AXI_WSTRB_I,   // Write strobes
  input  wire logic                       S_AXI_WVALID_I,  // Write data valid
  output logic                            S_AXI_WREADY_O,  // Write data ready
  output logic [1:0]                      S_AXI_BRESP_O,   // Write response
  output logic                            S_AXI_BVALID_O,  // Write response valid
  input  wire logic                       S_AXI_BREADY_I,  // Write response ready
  input  wire logic [afr_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,  // Read address
  input  wire logic                       S_AXI_ARVALID_I, // Read address valid
  output logic                            S_AXI_ARREADY_O, // Read address ready
  output logic [31:0]                     S_AXI_RDATA_O,   // Read data
  output logic [1:0]                      S_AXI_RRESP_O,   // Read response
  output logic                            S_AXI_RVALID_O,  // Read data valid
  input  wire logic                       S_AXI_RREADY_I   // Read data ready
);
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} afr_wr_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} afr_rd_t;

  // Byte view of the map, shared by single and looped reads
  function automatic logic [7:0] afr_byte(input logic [3:0] idx, input logic [23:0] c0,
      input logic [23:0] c1, input logic [39:0] cfg);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      4'h0: b = c0[23:16];
      4'h1: b = c0[15:8];
      4'h2: b = c0[7:0];
      4'h3: b = c1[23:16];
      4'h4: b = c1[15:8];
      4'h5: b = c1[7:0];
      4'h7: b = cfg[7:0];
      4'h8: b = cfg[15:8];
      4'h9: b = cfg[23:16];
      4'hA: b = cfg[31:24];
      4'hB: b = cfg[39:32];
      default: b = 8'h00;        // Reserved slot and beyond read zero
    endcase
    return b;
  endfunction : afr_byte

  // Set bounds; lo=1 gives the first address, lo=0 the last
  function automatic logic [3:0] afr_bound(input logic [1:0] sel, input logic [3:0] p,
      input logic lo);
    logic [3:0] f;
    logic [3:0] l;
    f = p;
    l = p;
    unique case (sel)
      afr_pkg::LOOP_GROUP: begin
        if (p <= afr_pkg::IDX_GRP1) begin
          f = afr_pkg::IDX_CH0;
          l = afr_pkg::IDX_GRP1;
        end else if (p <= afr_pkg::IDX_GRP2) begin
          f = afr_pkg::IDX_CH1;
          l = afr_pkg::IDX_GRP2;
        end else if (p <= afr_pkg::IDX_GAIN) begin
          f = afr_pkg::IDX_PHASE;
          l = afr_pkg::IDX_GAIN;
        end else begin
          f = afr_pkg::IDX_STAT;
          l = afr_pkg::IDX_CFGB;
        end
      end
      afr_pkg::LOOP_TYPE: begin
        f = (p <= afr_pkg::IDX_GRP2) ? afr_pkg::IDX_CH0 : afr_pkg::IDX_PHASE;
        l = (p <= afr_pkg::IDX_GRP2) ? afr_pkg::IDX_GRP2 : afr_pkg::IDX_CFGB;
      end
      afr_pkg::LOOP_ALL: begin
        f = afr_pkg::IDX_CH0;
        l = afr_pkg::IDX_CFGB;
      end
      default: begin             // No loop: address stays put
        f = p;
        l = p;
      end
    endcase
    return lo ? f : l;
  endfunction : afr_bound

  logic [47:0]  fifo_q;
  logic         fifo_valid;
  logic         pop;
  logic [23:0]  ch0_q;
  logic [23:0]  ch1_q;
  logic [23:0]  next_ch0_q;
  logic [23:0]  next_ch1_q;
  logic [39:0]  cfg;
  logic [39:0]  next_cfg;
  logic [1:0]   loop_sel;
  logic         loop_run;
  logic [3:0]   loop_ptr;
  logic [1:0]   next_loop_sel;
  logic         next_loop_run;
  logic [3:0]   next_loop_ptr;
  afr_wr_t      wr_st;
  afr_wr_t      next_wr_st;
  logic         aw_got;
  logic         w_got;
  logic         next_aw_got;
  logic         next_w_got;
  logic [3:0]   wr_idx;
  logic [3:0]   next_wr_idx;
  logic [7:0]   wr_byte;
  logic [7:0]   next_wr_byte;
  logic         wr_en;
  logic         next_wr_en;
  logic [1:0]   bresp;
  logic [1:0]   next_bresp;
  logic         wr_do;
  afr_rd_t      rd_st;
  afr_rd_t      next_rd_st;
  logic [31:0]  rdata;
  logic [31:0]  next_rdata;
  logic [1:0]   rresp;
  logic [1:0]   next_rresp;
  logic [3:0]   ar_idx;
  logic         ar_take;
  logic         rd_adv;
  logic         wr_loop;

  afr_fifo #(
    .WIDTH (48),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RSTN_I),
    .in_valid_i  (SAMPLE_VALID_I),
    .in_ready_o  (SAMPLE_READY_O),
    .in_data_i   ({CH1_SAMPLE_I, CH0_SAMPLE_I}),
    .out_valid_o (fifo_valid),
    .out_ready_i (!loop_run),
    .out_data_o  (fifo_q)
  );

  // A running loop freezes the results; the FIFO absorbs the stall
  assign pop = fifo_valid && !loop_run;

  always_comb begin
    next_ch0_q = pop ? fifo_q[23:0] : ch0_q;
    next_ch1_q = pop ? fifo_q[47:24] : ch1_q;
  end

  // Write channel: address and data taken in either order
  assign S_AXI_AWREADY_O = (wr_st == WR_IDLE) && !aw_got;
  assign S_AXI_WREADY_O  = (wr_st == WR_IDLE) && !w_got;
  assign S_AXI_BVALID_O  = (wr_st == WR_RESP);
  assign S_AXI_BRESP_O   = bresp;
  assign wr_do           = (wr_st == WR_IDLE) && aw_got && w_got;
  assign wr_loop         = wr_do && wr_en && (wr_idx == afr_pkg::IDX_LOOP);

  always_comb begin
    next_wr_st   = wr_st;
    next_aw_got  = aw_got;
    next_w_got   = w_got;
    next_wr_idx  = wr_idx;
    next_wr_byte = wr_byte;
    next_wr_en   = wr_en;
    next_bresp   = bresp;
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      next_aw_got = 1'b1;
      next_wr_idx = S_AXI_AWADDR_I[afr_pkg::ADDR_W-1:2];
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      next_w_got   = 1'b1;
      next_wr_byte = S_AXI_WDATA_I[7:0];
      next_wr_en   = S_AXI_WSTRB_I[0];
    end
    if (wr_do) begin
      next_wr_st = WR_RESP;
      next_bresp = (wr_idx > afr_pkg::IDX_STREAM) ? afr_pkg::RESP_SLVERR : afr_pkg::RESP_OKAY;
    end
    if ((wr_st == WR_RESP) && S_AXI_BREADY_I) begin
      next_wr_st  = WR_IDLE;
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
    end
  end

  // Configuration bytes; result and reserved slots ignore writes
  always_comb begin
    next_cfg = cfg;
    if (wr_do && wr_en && wr_idx >= afr_pkg::IDX_PHASE && wr_idx <= afr_pkg::IDX_CFGB) begin
      next_cfg[(wr_idx - afr_pkg::IDX_PHASE)*8 +: 8] = wr_byte;
    end
  end

  // Read channel and loop pointer
  assign S_AXI_ARREADY_O = (rd_st == RD_IDLE);
  assign S_AXI_RVALID_O  = (rd_st == RD_RESP);
  assign S_AXI_RDATA_O   = rdata;
  assign S_AXI_RRESP_O   = rresp;
  assign ar_idx          = S_AXI_ARADDR_I[afr_pkg::ADDR_W-1:2];
  assign ar_take         = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_adv          = ar_take && (ar_idx == afr_pkg::IDX_STREAM);

  always_comb begin
    next_rd_st = rd_st;
    next_rdata = rdata;
    next_rresp = rresp;
    if (ar_take) begin
      next_rd_st = RD_RESP;
      next_rresp = afr_pkg::RESP_OKAY;
      if (ar_idx == afr_pkg::IDX_LOOP) begin
        next_rdata = {24'h00_0000, loop_ptr, 1'b0, loop_run, loop_sel};
      end else if (ar_idx == afr_pkg::IDX_STREAM) begin
        next_rdata = {24'h00_0000, afr_byte(loop_ptr, ch0_q, ch1_q, cfg)};
      end else if (ar_idx > afr_pkg::IDX_STREAM) begin
        next_rdata = 32'h0000_0000;
        next_rresp = afr_pkg::RESP_SLVERR;
      end else begin
        next_rdata = {24'h00_0000, afr_byte(ar_idx, ch0_q, ch1_q, cfg)};
      end
    end
    if ((rd_st == RD_RESP) && S_AXI_RREADY_I) begin
      next_rd_st = RD_IDLE;
    end
  end

  always_comb begin
    next_loop_sel = loop_sel;
    next_loop_run = loop_run;
    next_loop_ptr = loop_ptr;
    if (wr_loop) begin
      next_loop_sel = wr_byte[afr_pkg::LOOP_SEL_LSB +: 2];
      next_loop_run = wr_byte[afr_pkg::LOOP_RUN_BIT];
      next_loop_ptr = wr_byte[afr_pkg::LOOP_START_LSB +: 4];
    end else if (rd_adv) begin
      if (loop_ptr == afr_bound(loop_sel, loop_ptr, 1'b0)) begin
        next_loop_ptr = afr_bound(loop_sel, loop_ptr, 1'b1);
      end else begin
        next_loop_ptr = loop_ptr + 4'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ch0_q    <= afr_pkg::RST_SAMPLE;
      ch1_q    <= afr_pkg::RST_SAMPLE;
      cfg      <= {5{afr_pkg::RST_CFG}};
      loop_sel <= afr_pkg::LOOP_NONE;
      loop_run <= 1'b0;
      loop_ptr <= afr_pkg::IDX_CH0;
      wr_st    <= WR_IDLE;
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      wr_idx   <= 4'h0;
      wr_byte  <= 8'h00;
      wr_en    <= 1'b0;
      bresp    <= afr_pkg::RESP_OKAY;
      rd_st    <= RD_IDLE;
      rdata    <= 32'h0000_0000;
      rresp    <= afr_pkg::RESP_OKAY;
    end else begin
      ch0_q    <= next_ch0_q;
      ch1_q    <= next_ch1_q;
      cfg      <= next_cfg;
      loop_sel <= next_loop_sel;
      loop_run <= next_loop_run;
      loop_ptr <= next_loop_ptr;
      wr_st    <= next_wr_st;
      aw_got   <= next_aw_got;
      w_got    <= next_w_got;
      wr_idx   <= next_wr_idx;
      wr_byte  <= next_wr_byte;
      wr_en    <= next_wr_en;
      bresp    <= next_bresp;
      rd_st    <= next_rd_st;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  default clocking afr_cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  hold_snapshot_a: assert property (loop_run |=> $stable(ch0_q) && $stable(ch1_q))
    else $error("result changed while loop read running");
  both_refresh_a: assert property (pop |=> ch0_q == $past(fifo_q[23:0])
      && ch1_q == $past(fifo_q[47:24]))
    else $error("channels not refreshed together");
  ch0_msb_a: assert property (ar_take && ar_idx == afr_pkg::IDX_CH0
      |=> S_AXI_RVALID_O && S_AXI_RDATA_O == {24'h00_0000, $past(ch0_q[23:16])})
    else $error("channel 0 top byte not at its slot");
  ch1_msb_a: assert property (ar_take && ar_idx == afr_pkg::IDX_CH1
      |=> S_AXI_RDATA_O == {24'h00_0000, $past(ch1_q[23:16])})
    else $error("channel 1 top byte not at its slot");
  gain_store_a: assert property (wr_do && wr_en && wr_idx == afr_pkg::IDX_GAIN
      |=> cfg[15:8] == $past(wr_byte) && S_AXI_BVALID_O)
    else $error("gain byte not stored");
  byte_wide_a: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h00_0000)
    else $error("read wider than one byte");
  all_wrap_a: assert property (rd_adv && !wr_loop && loop_sel == afr_pkg::LOOP_ALL
      && loop_ptr == afr_pkg::IDX_CFGB |=> loop_ptr == afr_pkg::IDX_CH0)
    else $error("whole-map loop did not wrap");
  group_wrap_a: assert property (rd_adv && !wr_loop && loop_sel == afr_pkg::LOOP_GROUP
      && loop_ptr == afr_pkg::IDX_GRP1 |=> loop_ptr == afr_pkg::IDX_CH0)
    else $error("group loop did not wrap");
  type_wrap_a: assert property (rd_adv && !wr_loop && loop_sel == afr_pkg::LOOP_TYPE
      && loop_ptr == afr_pkg::IDX_CFGB |=> loop_ptr == afr_pkg::IDX_PHASE)
    else $error("type loop sequence wrong");
endmodule : afr_top

`default_nettype wire

// File: afr_src.sv
// Conversion source model that offers sample pairs to the front end
`timescale 1ns/100ps
`default_nettype none
module afr_src #(
  parameter int COUNT = 17
) (
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_n_i, // Async reset, active low
  input  wire logic        en_i,    // Start offering pairs
  input  wire logic        ready_i, // Front end takes a pair
  output logic             valid_o, // Pair offered
  output logic      [23:0] ch0_o,   // Channel 0 conversion
  output logic      [23:0] ch1_o    // Channel 1 conversion
);
  logic [7:0] k;
  logic [7:0] next_k;
  always_comb begin
    valid_o = en_i && (k < COUNT[7:0]);
    next_k  = (valid_o && ready_i) ? k + 8'h01 : k;
    // Idle payload flips so a stale pair never passes for a fresh one
    ch0_o   = valid_o ? {8'hA1, k, 8'h3C} : ~{8'hA1, k, 8'h3C};
    ch1_o   = valid_o ? {8'h5E, 8'hC7, k} : ~{8'h5E, 8'hC7, k};
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) k <= 8'h00;
    else k <= next_k;
  end
endmodule : afr_src
`default_nettype wire

// File: afe_register_map_readout_bench.sv
// Self-checking bench for the front-end register bank
`timescale 1ns/100ps
`default_nettype none
module afe_register_map_readout_bench;
  typedef struct packed {logic [3:0] idx; logic [7:0] d; logic [1:0] resp;} afr_row_t;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        src_en  = 1'b0;
  logic [23:0] ch0, ch1;
  logic        s_valid, s_ready, awready, wready, bvalid, arready, rvalid;
  logic [5:0]  awaddr  = 6'h00;
  logic [5:0]  araddr  = 6'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  d;
  logic [7:0]  exp_mem [16];
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_push = 0;
  int          n;
  afr_row_t    rows [10] = '{'{4'h7, 8'hA5, 2'h0}, '{4'h8, 8'h5A, 2'h0}, '{4'h9, 8'h3C, 2'h0},
    '{4'hA, 8'hC3, 2'h0}, '{4'hB, 8'hFF, 2'h0}, '{4'h0, 8'h77, 2'h0}, '{4'h3, 8'h88, 2'h0},
    '{4'hD, 8'h11, 2'h0}, '{4'hE, 8'h01, 2'h2}, '{4'hF, 8'h02, 2'h2}};

  afr_top #(.FIFO_DEPTH(16)) i_dut (
    .REF_CLK_I(ref_clk), .RSTN_I(rstn), .CH0_SAMPLE_I(ch0), .CH1_SAMPLE_I(ch1),
    .SAMPLE_VALID_I(s_valid), .SAMPLE_READY_O(s_ready),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
  afr_src #(.COUNT(17)) i_src (.clk_i(ref_clk), .rst_n_i(rstn), .en_i(src_en),
    .ready_i(s_ready), .valid_o(s_valid), .ch0_o(ch0), .ch1_o(ch1));

  always #2 ref_clk = ~ref_clk;
  // Counted mid-cycle, where the handshake pair stands settled
  always @(negedge ref_clk) if (s_valid && s_ready) n_push <= n_push + 1;

  task automatic test_done;
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk_num(input string what, input int e, input int g);
    num_checks++;
    if (g != e) begin
      n_errors++;
      $display("BAD %s exp %0d got %0d", what, e, g);
    end
  endtask : chk_num

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk_byte

  task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk_resp

  task automatic give_up;
    chk_num("timeout", 0, 1);
    test_done();
  endtask : give_up

  // Address and data offered together; each dropped at its own handshake
  task automatic axi_wr(input logic [3:0] idx, input logic [7:0] v, output logic [1:0] rs);
    int k;
    logic aw_hs, w_hs, b_hs;
    k = 0;
    b_hs = 1'b0;
    rs = 2'h0;
    @(posedge ref_clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      // Readies are combinational; look before the edge that takes them
      @(negedge ref_clk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid && bready;
      rs    = bresp;
      @(posedge ref_clk);
      k++;
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end while (!b_hs && k < 200);
    if (!b_hs) give_up();
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] idx, output logic [7:0] v, output logic [1:0] rs);
    int k;
    logic ar_hs, r_hs;
    k = 0;
    r_hs = 1'b0;
    v = 8'h00;
    rs = 2'h0;
    @(posedge ref_clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge ref_clk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid && rready;
      v     = rdata[7:0];
      rs    = rresp;
      @(posedge ref_clk);
      k++;
      if (ar_hs) arvalid <= 1'b0;
    end while (!r_hs && k < 200);
    if (!r_hs) give_up();
    rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic [7:0] v;
    logic [1:0] rs;
    axi_rd(idx, v, rs);
    chk_byte($sformatf("read %h", idx), e, v);
    chk_resp($sformatf("rresp %h", idx), er, rs);
  endtask : rd_chk

  // Pointer walks the chosen set and wraps from its last index to its first
  task automatic stream_chk(input logic [1:0] sel, input logic [3:0] first,
                            input logic [3:0] last, input int nrd);
    logic [3:0] p;
    logic [1:0] rs;
    p = first;
    axi_wr(4'hC, {first, 2'b01, sel}, rs);
    repeat (nrd) begin
      rd_chk(4'hD, exp_mem[p], 2'h0);
      p = (p == last) ? first : p + 4'h1;
    end
  endtask : stream_chk

  initial begin
    for (int i = 0; i < 16; i++) exp_mem[i] = 8'h00;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      axi_wr(rows[i].idx, rows[i].d, r);
      chk_resp("bresp", rows[i].resp, r);
      if (rows[i].idx inside {[4'h7:4'hB]}) exp_mem[rows[i].idx] = rows[i].d;
      rd_chk(rows[i].idx, exp_mem[rows[i].idx], rows[i].resp);
    end
    // Hold pops so the FIFO fills and refuses the last pair
    axi_wr(4'hC, 8'h04, r);
    src_en <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk_num("pairs taken while held", 16, n_push);
    chk_byte("ready when full", 8'h00, {7'h00, s_ready});
    rd_chk(4'h2, 8'h00, 2'h0);
    axi_wr(4'hC, 8'h00, r);
    n = 0;
    do begin
      axi_rd(4'h5, d, r);
      n++;
    end while (d !== 8'h10 && n < 60);
    if (n >= 60) give_up();
    chk_num("pairs taken", 17, n_push);
    exp_mem[0:5] = '{8'hA1, 8'h10, 8'h3C, 8'h5E, 8'hC7, 8'h10};
    for (int i = 0; i < 6; i++) rd_chk(i[3:0], exp_mem[i], 2'h0);
    stream_chk(2'h3, 4'h0, 4'hB, 14);
    stream_chk(2'h2, 4'h0, 4'h5, 7);
    stream_chk(2'h2, 4'h7, 4'hB, 6);
    stream_chk(2'h1, 4'h0, 4'h2, 4);
    stream_chk(2'h1, 4'h3, 4'h5, 4);
    stream_chk(2'h1, 4'h7, 4'h8, 3);
    stream_chk(2'h1, 4'h9, 4'hB, 4);
    stream_chk(2'h0, 4'h9, 4'h9, 3);
    // Second reset in mid-run clears results and configuration
    src_en <= 1'b0;
    rstn   <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 14; i++) rd_chk(i[3:0], 8'h00, 2'h0);
    test_done();
  end
endmodule : afe_register_map_readout_bench
`default_nettype wire
